// ===== hdl/pcxm_defines.vh
// Constants for the configuration and I/O transaction proxy.
// Assumes inclusion by bare name from the design files.
`ifndef PCXM_DEFINES_VH
`define PCXM_DEFINES_VH

// ====================================================================
// Register byte offsets
`define PCXM_OFF_DATA      12'h000
`define PCXM_OFF_ADDR      12'h004
`define PCXM_OFF_CMD       12'h008
`define PCXM_OFF_MCFG      12'h00C
`define PCXM_OFF_CTRL      12'h010

// ====================================================================
// Command register fields
`define PCXM_CMD_READY     31
`define PCXM_CMD_BE_HI     7
`define PCXM_CMD_BE_LO     4
`define PCXM_CMD_TYPE      2
`define PCXM_CMD_RDWR      0
// Master configuration fields
`define PCXM_MCFG_CFGFL    10
`define PCXM_MCFG_IOFL     9
// Control register field
`define PCXM_CTRL_MEN      0

// ====================================================================
// Reset values
`define PCXM_RST_WORD      32'h0000_0000
`define PCXM_RST_BE        4'hF

// ====================================================================
// PCI command codes and timing
`define PCXM_PCI_IORD      4'h2
`define PCXM_PCI_IOWR      4'h3
`define PCXM_PCI_CFGRD     4'hA
`define PCXM_PCI_CFGWR     4'hB
`define PCXM_TIMEOUT_CYC   8'h40

`endif

// ===== hdl/pcxm_sync.v
// Two-flop synchroniser for a single level from outside the clock domain.
// Assumes hclk and an active-low asynchronous reset.
`timescale 1ns/1ps

module pcxm_sync (
  input  wire hclk,
  input  wire hresetn,
  input  wire d,
  output wire q
);

  reg meta_q;
  reg sync_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // pcxm_sync

// ===== hdl/pcxm_proxy.v
// AHB-Lite slave proxy that issues single PCI configuration or I/O cycles.
// Assumes a simple single-beat PCI master back end with a req/ack handshake.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "pcxm_defines.vh"

// Summary of operation
// - A command register write launches a PCI transaction, or a control write enabling the master while one is held.
// - Full 32-bit address reaches all configuration and I/O space.
// - Data register supplies write data and holds returned read data.
// - Address register gives the address; low two bits dropped for configuration.
// - Command bit 31 reads one when a new command can be accepted.
// - Four-bit byte-lane field selects accessed bytes and transfer size.
// - Kind bit zero gives configuration, one gives I/O.
// - Direction bit zero gives write, one gives read.
// - Master disabled with configuration flush set discards pending configuration commands.
// - Master disabled with I/O flush set discards pending I/O; clear holds them.
module pcxm_proxy (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output wire        pci_req,
  output wire [3:0]  pci_cmd,
  output wire [31:0] pci_addr,
  output wire [3:0]  pci_be_n,
  output wire [31:0] pci_wdata,
  input  wire        pci_ack,
  input  wire [31:0] pci_rdata
);

  // ==================================================================
  // States and bus decode
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_DONE = 2'b10;

  function sel_reg;
    input [11:0] a;
    input [11:0] off;
    begin
      sel_reg = (a == off);
    end
  endfunction

  reg        wr_pend_q;
  reg [11:0] wr_addr_q;
  reg [31:0] hrdata_q;
  reg [31:0] data_q;
  reg [31:0] addr_q;
  reg [3:0]  be_q;
  reg        type_q;
  reg        rdwr_q;
  reg        ready_q;
  reg        cfg_flush_q;
  reg        io_flush_q;
  reg        men_q;
  reg [1:0]  state_q;
  reg        req_q;
  reg [3:0]  pcmd_q;
  reg [31:0] paddr_q;
  reg [3:0]  pbe_q;
  reg [31:0] pwdata_q;
  reg        ack_prev_q;
  reg        hreadyout_q;
  reg        hresp_q;
  wire       ack_s;
  reg [31:0] rd_mux;

  wire addr_phase = hsel && hready && htrans[1];
  wire rd_take    = addr_phase && !hwrite;
  wire cmd_wr     = wr_pend_q && sel_reg(wr_addr_q, `PCXM_OFF_CMD);
  wire flush_now  = !men_q && (type_q ? io_flush_q : cfg_flush_q);

  // The acknowledge comes from the PCI clock side, so it is synchronised and edge detected.
  pcxm_sync u_ack_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pci_ack),
    .q       (ack_s)
  );
  wire ack_rise = ack_s && !ack_prev_q;

  // ==================================================================
  // Read mux
  always @* begin
    rd_mux = `PCXM_RST_WORD;
    case (haddr[11:0])
      `PCXM_OFF_DATA: rd_mux = data_q;
      `PCXM_OFF_ADDR: rd_mux = addr_q;
      `PCXM_OFF_CMD: begin
        rd_mux[`PCXM_CMD_READY] = ready_q;
        rd_mux[`PCXM_CMD_BE_HI:`PCXM_CMD_BE_LO] = be_q;
        rd_mux[`PCXM_CMD_TYPE] = type_q;
        rd_mux[`PCXM_CMD_RDWR] = rdwr_q;
      end
      `PCXM_OFF_MCFG: begin
        rd_mux[`PCXM_MCFG_CFGFL] = cfg_flush_q;
        rd_mux[`PCXM_MCFG_IOFL] = io_flush_q;
      end
      `PCXM_OFF_CTRL: rd_mux[`PCXM_CTRL_MEN] = men_q;
      default: rd_mux = `PCXM_RST_WORD;
    endcase
  end

  // ==================================================================
  // Bus slave and registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 12'h000;
      hrdata_q    <= `PCXM_RST_WORD;
      data_q      <= `PCXM_RST_WORD;
      addr_q      <= `PCXM_RST_WORD;
      be_q        <= `PCXM_RST_BE;
      type_q      <= 1'b0;
      rdwr_q      <= 1'b0;
      cfg_flush_q <= 1'b0;
      io_flush_q  <= 1'b0;
      men_q       <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr[11:0];
      end
      if (rd_take) begin
        hrdata_q <= rd_mux;
      end
      if (wr_pend_q) begin
        if (sel_reg(wr_addr_q, `PCXM_OFF_DATA) && ready_q) begin
          data_q <= hwdata;
        end
        if (sel_reg(wr_addr_q, `PCXM_OFF_ADDR) && ready_q) begin
          addr_q <= hwdata;
        end
        if (cmd_wr && ready_q) begin
          be_q   <= hwdata[`PCXM_CMD_BE_HI:`PCXM_CMD_BE_LO];
          type_q <= hwdata[`PCXM_CMD_TYPE];
          rdwr_q <= hwdata[`PCXM_CMD_RDWR];
        end
        if (sel_reg(wr_addr_q, `PCXM_OFF_MCFG)) begin
          cfg_flush_q <= hwdata[`PCXM_MCFG_CFGFL];
          io_flush_q  <= hwdata[`PCXM_MCFG_IOFL];
        end
        if (sel_reg(wr_addr_q, `PCXM_OFF_CTRL)) begin
          men_q <= hwdata[`PCXM_CTRL_MEN];
        end
      end
      // Read data lands in the data register on the same edge that ready returns.
      if (state_q == ST_WAIT && ack_rise && rdwr_q) begin
        data_q <= pci_rdata;
      end
    end
  end

  // ==================================================================
  // Transaction sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= ST_IDLE;
      ready_q    <= 1'b1;
      req_q      <= 1'b0;
      pcmd_q     <= 4'h0;
      paddr_q    <= `PCXM_RST_WORD;
      pbe_q      <= 4'hF;
      pwdata_q   <= `PCXM_RST_WORD;
      ack_prev_q <= 1'b0;
    end else begin
      ack_prev_q <= ack_s;
      case (state_q)
        ST_IDLE: begin
          if (cmd_wr && ready_q) begin
            ready_q <= 1'b0;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Launch one cycle after the command lands so the fields are stable.
          if (flush_now) begin
            ready_q <= 1'b1;
            state_q <= ST_IDLE;
          end else if (men_q) begin
            req_q    <= 1'b1;
            pcmd_q   <= type_q ? (rdwr_q ? `PCXM_PCI_IORD : `PCXM_PCI_IOWR)
                               : (rdwr_q ? `PCXM_PCI_CFGRD : `PCXM_PCI_CFGWR);
            paddr_q  <= type_q ? addr_q : {addr_q[31:2], 2'b00};
            pbe_q    <= ~be_q;
            pwdata_q <= data_q;
            state_q  <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ack_rise) begin
            req_q   <= 1'b0;
            ready_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==================================================================
  // Bus answer flops
  // The slave never stretches a transfer and never reports an error, but both answers come from flops.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign pci_req   = req_q;
  assign pci_cmd   = pcmd_q;
  assign pci_addr  = paddr_q;
  assign pci_be_n  = pbe_q;
  assign pci_wdata = pwdata_q;

endmodule // pcxm_proxy

// ===== bench/pcxm_sva.sv
// Checker for the proxy's bus answer and PCI request ports.
// Assumes it is bound to pcxm_proxy in one hclk domain.
`timescale 1ns/1ps
module pcxm_sva (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        pci_req,
  input wire [3:0]  pci_cmd,
  input wire [31:0] pci_addr,
  input wire        pci_ack
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ====
  // Helpers
  reg wr_q;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= hsel & hready & htrans[1] & hwrite;
  sequence s_ack_rise; $rose(pci_ack); endsequence
  sequence s_req_drop; ##[1:6] !pci_req; endsequence
  // ====
  // Properties
  a_zero_wait: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  a_launch_on_write: assert property ($rose(pci_req) |-> $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3))
    else $error("request without a register write");
  a_req_holds: assert property (pci_req && !pci_ack |=> pci_req) else $error("request dropped early");
  a_fields_stable: assert property (pci_req && !pci_ack |=> $stable(pci_cmd) && $stable(pci_addr))
    else $error("request fields moved");
  a_cmd_legal: assert property (pci_req |-> pci_cmd inside {4'h2, 4'h3, 4'hA, 4'hB})
    else $error("illegal command code");
  a_cfg_addr_low: assert property (pci_req && pci_cmd[3] |-> pci_addr[1:0] == 2'h0)
    else $error("cfg address low bits set");
  a_req_release: assert property (s_ack_rise |-> s_req_drop) else $error("request not released");
endmodule // pcxm_sva

// ===== bench/pcxm_target.sv
// PCI target model answering one proxied cycle at a time.
// Assumes the proxy holds its request until it sees the acknowledge.
`timescale 1ns/1ps
module pcxm_target #(parameter DLY = 9) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        pci_req,
  input  wire [31:0] pci_addr,
  output reg         pci_ack,
  output wire [31:0] pci_rdata
);
  reg [7:0] cnt_q;
  reg       slow_q;
  // Outside an acknowledge the data lines show a value that cannot pass for the answer.
  assign pci_rdata = pci_ack ? (pci_addr ^ 32'hA5A5_0000) : ~(pci_addr ^ 32'hA5A5_0000);
  // Alternate prompt and slow answers.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pci_ack <= 1'b0;
      cnt_q   <= 8'h0;
      slow_q  <= 1'b0;
    end else if (!pci_req) begin
      pci_ack <= 1'b0;
      cnt_q   <= 8'h0;
      if (pci_ack) slow_q <= ~slow_q;
    end else if (cnt_q == (slow_q ? DLY : 2)) pci_ack <= 1'b1;
    else cnt_q <= cnt_q + 8'h1;
  end
endmodule // pcxm_target

// ===== bench/tb_pci_cfg_io_proxy_master.sv
// Bench driving the proxy registers over AHB-Lite against a PCI target model.
// Assumes pcxm_proxy, pcxm_target and pcxm_sva are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_pci_cfg_io_proxy_master;
  reg         hclk, hresetn, hsel, hwrite;
  reg  [1:0]  htrans;
  reg  [31:0] haddr, hwdata, rd, ea, cs_addr, cs_wd;
  reg  [7:0]  cs;
  wire [31:0] hrdata, pci_addr, pci_wdata, pci_rdata;
  wire        hreadyout, hresp, pci_req, pci_ack;
  wire [3:0]  pci_cmd, pci_be_n;
  int         failures, num_checks, nreq, k;
  pcxm_proxy u_pcxm_proxy (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pci_req(pci_req), .pci_cmd(pci_cmd), .pci_addr(pci_addr), .pci_be_n(pci_be_n),
    .pci_wdata(pci_wdata), .pci_ack(pci_ack), .pci_rdata(pci_rdata));
  pcxm_target u_pcxm_target (.hclk(hclk), .hresetn(hresetn), .pci_req(pci_req), .pci_addr(pci_addr),
    .pci_ack(pci_ack), .pci_rdata(pci_rdata));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Fields are caught just after the request rises, since a prompt target may end it fast.
  always @(posedge pci_req) begin
    #1;
    nreq++;
    cs = {pci_cmd, pci_be_n};
    cs_addr = pci_addr;
    cs_wd = pci_wdata;
  end
  // ====
  // Bus tasks
  task ahb(input w, input [11:0] a, input [31:0] d);
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task poll;
    rd = 32'h0;
    for (int i = 0; i < 100 && rd[31] !== 1'b1; i++) ahb(1'b0, 12'h008, 32'h0);
    `CHK("ready", 1'b1, rd[31])
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #500us;
    failures++;
    end_of_test;
  end
  // ====
  // Tests
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 12'h008, 32'h0);
    `CHK("cmd_reset", 32'h8000_00F0, rd)
    ahb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    ahb(1'b1, 12'h010, 32'h1);
    for (k = 0; k < 4; k++) begin
      ea = k[1] ? 32'hFEDC_BA90 + 4 * k : 32'hFEDC_BA93 + k;
      ahb(1'b1, 12'h000, 32'h1234_5670 + k);
      ahb(1'b1, 12'h004, ea);
      `CHK("early_req", 1'b0, pci_req)
      ahb(1'b1, 12'h008, 32'h7FFF_FF5A | {k[1], 1'b0, k[0]});
      ahb(1'b0, 12'h008, 32'h0);
      `CHK("busy", 1'b0, rd[31])
      ahb(1'b1, 12'h004, 32'h0);
      poll;
      `CHK("cmd_fields", 32'h8000_0050 | {k[1], 1'b0, k[0]}, rd)
      ahb(1'b0, 12'h004, 32'h0);
      `CHK("addr_kept", ea, rd)
      if (!k[1]) ea[1:0] = 2'h0;
      `CHK("cmd_be", {~k[1], 2'h1, ~k[0], 4'hA}, cs)
      `CHK("pci_addr", ea, cs_addr)
      if (!k[0]) `CHK("pci_wdata", 32'h1234_5670 + k, cs_wd)
      ahb(1'b0, 12'h000, 32'h0);
      `CHK("data", k[0] ? ea ^ 32'hA5A5_0000 : 32'h1234_5670 + k, rd)
    end
    ahb(1'b1, 12'h010, 32'h0);
    ahb(1'b1, 12'h00C, 32'h0);
    ahb(1'b1, 12'h008, 32'h54);
    ahb(1'b0, 12'h008, 32'h0);
    `CHK("held", 1'b0, rd[31])
    ahb(1'b1, 12'h00C, 32'h200);
    poll;
    ahb(1'b1, 12'h00C, 32'h400);
    ahb(1'b1, 12'h008, 32'h50);
    poll;
    `CHK("flushed", 4, nreq)
    ahb(1'b1, 12'h00C, 32'h0);
    ahb(1'b1, 12'h004, 32'h0000_0108);
    ahb(1'b1, 12'h008, 32'h51);
    ahb(1'b1, 12'h010, 32'h1);
    poll;
    `CHK("released", 5, nreq)
    `CHK("rd_addr", 32'h0000_0108, cs_addr)
    ahb(1'b0, 12'h000, 32'h0);
    `CHK("rd_data", 32'hA5A5_0108, rd)
    end_of_test;
  end
endmodule // tb_pci_cfg_io_proxy_master
bind pcxm_proxy pcxm_sva u_pcxm_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .pci_req(pci_req),
  .pci_cmd(pci_cmd), .pci_addr(pci_addr), .pci_ack(pci_ack));
